// [hdl/wdt_map.svh]
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

// Register offsets on the plain register port
`define WDT_ADDR_CTRL_ONE 8'h34
`define WDT_ADDR_KEY_CODE 8'h35
`define WDT_ADDR_STATUS 8'h36

// Field positions in watchdog_control_one
`define WDT_BIT_ENABLE 3
`define WDT_BIT_TT_HI 2
`define WDT_BIT_TT_LO 1
`define WDT_BIT_ACTION 0

// Reset values
`define WDT_CTRL_ONE_RESET 8'h09
`define WDT_TT_RESET 2'h0
`define WDT_ACTION_RESET 1'h1

// Key codes
`define WDT_CODE_CLEAR 8'h4E
`define WDT_CODE_DISABLE 8'hB1

// Divider widths: tap for code 00 before the two-stage counter
`define WDT_HF_DIV_BITS 23
`define WDT_LF_DIV_BITS 15

// Timing of the reset request
`define WDT_CLK_PERIOD_NS 5
`define WDT_RESET_TIME_NS 120
`define WDT_RESET_CYCLES (`WDT_RESET_TIME_NS / `WDT_CLK_PERIOD_NS)
`define WDT_RESET_CNT_BITS 5

`endif

// [hdl/wdt_pkg.sv]
`default_nettype none

package wdt_pkg;

  // Run state of the watchdog
  typedef enum logic [1:0] {
    WDT_ST_RUN = 2'b00,
    WDT_ST_ARMED_OFF = 2'b01,
    WDT_ST_OFF = 2'b10
  } wdt_state_t;

endpackage

`default_nettype wire

// [hdl/wdt_divider.sv]
`timescale 1ns/10ps
`default_nettype none
`include "wdt_map.svh"

module wdt_divider #(
  parameter int HF_BITS = `WDT_HF_DIV_BITS,
  parameter int LF_BITS = `WDT_LF_DIV_BITS
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic low_freq_clock_in,
  input wire logic hold_in,
  input wire logic use_low_in,
  input wire logic [1:0] time_sel_in,
  output logic tick_out
);

  logic [HF_BITS-1:0] hf_div_r;
  logic [HF_BITS-1:0] hf_div_nxt;
  logic [LF_BITS-1:0] lf_div_r;
  logic [LF_BITS-1:0] lf_div_nxt;
  logic lf_sync1_r;
  logic lf_sync2_r;
  logic lf_prev_r;
  logic tick_r;
  logic tick_nxt;
  logic lf_rise;
  logic [HF_BITS-1:0] hf_mask;
  logic [LF_BITS-1:0] lf_mask;

  // Dividers never see the clear code; only the hold modes stop them
  always_comb
  begin
    lf_rise = lf_sync2_r & ~lf_prev_r;
    hf_mask = {HF_BITS{1'b1}} >> {time_sel_in, 1'b0};
    lf_mask = {LF_BITS{1'b1}} >> {time_sel_in, 1'b0};
    hf_div_nxt = hold_in ? hf_div_r : HF_BITS'(hf_div_r + 1'b1);
    lf_div_nxt = (hold_in || !lf_rise) ? lf_div_r :
                 LF_BITS'(lf_div_r + 1'b1);
    if (hold_in)
    begin
      tick_nxt = 1'b0;
    end
    else if (use_low_in)
    begin
      tick_nxt = lf_rise && (&(lf_div_r | ~lf_mask));
    end
    else
    begin
      tick_nxt = &(hf_div_r | ~hf_mask);
    end
  end

  // Low clock pin passes two flops before the edge detector
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      hf_div_r <= '0;
      lf_div_r <= '0;
      lf_sync1_r <= 1'b0;
      lf_sync2_r <= 1'b0;
      lf_prev_r <= 1'b0;
      tick_r <= 1'b0;
    end
    else
    begin
      hf_div_r <= hf_div_nxt;
      lf_div_r <= lf_div_nxt;
      lf_sync1_r <= low_freq_clock_in;
      lf_sync2_r <= lf_sync1_r;
      lf_prev_r <= lf_sync2_r;
      tick_r <= tick_nxt;
    end
  end

  assign tick_out = tick_r;

endmodule
`default_nettype wire

// [hdl/wdt_reset_stretch.sv]
`timescale 1ns/10ps
`default_nettype none
`include "wdt_map.svh"

module wdt_reset_stretch (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic trig_in,
  output logic active_out
);

  localparam logic [`WDT_RESET_CNT_BITS-1:0] RESET_CYCLES =
    `WDT_RESET_CNT_BITS'(`WDT_RESET_CYCLES);

  logic [`WDT_RESET_CNT_BITS-1:0] cnt_r;
  logic [`WDT_RESET_CNT_BITS-1:0] cnt_nxt;
  logic active_r;
  logic active_nxt;

  // A new trigger restarts the full length, so repeated triggers hold it past the limit
  always_comb
  begin
    if (trig_in)
    begin
      cnt_nxt = RESET_CYCLES;
    end
    else if (cnt_r != '0)
    begin
      cnt_nxt = cnt_r - 1'b1;
    end
    else
    begin
      cnt_nxt = cnt_r;
    end
    active_nxt = (cnt_nxt != '0);
  end

  // Counter and output flop
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_r <= '0;
      active_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      active_r <= active_nxt;
    end
  end

  assign active_out = active_r;

endmodule
`default_nettype wire

// [hdl/wdt_top.sv]
// Notes on behaviour
// - Watchdog is enabled and counting right after reset release.
// - Overflow action resets to reset request; may change once.
// - Overflow with action bit 1 issues a reset request.
// - Overflow with action bit 0 raises the watchdog interrupt.
// - Count freezes in stop, idle and sleep, then resumes.
// - Divider plus two-stage counter; clear code clears counter only.
// - Time select picks period, each step divides by four.
// - Once action bit is 0, writes of 1 are ignored.
// - Control one is write-only; reads give no useful data.
// - Disable code acts only while the enable bit is already 0.
// - With interrupt action, overflow serves as periodic interrupt.
// - While disabled, the binary counter is held cleared.
// - Watchdog interrupt is non-maskable.
// - Reset request lasts 24 high-frequency clocks; each new overflow restarts the full length.
`timescale 1ns/10ps
`default_nettype none
`include "wdt_map.svh"

module wdt_top #(
  parameter int HF_DIV_BITS = `WDT_HF_DIV_BITS,
  parameter int LF_DIV_BITS = `WDT_LF_DIV_BITS
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic low_freq_clock_in,
  input wire logic slow_mode_in,
  input wire logic stop_mode_in,
  input wire logic idle_mode_in,
  input wire logic sleep_mode_in,
  input wire logic divider_stage_select_in,
  output logic [7:0] rd_data_out,
  output logic watchdog_interrupt_request_out,
  output logic wdt_reset_request_out
);

  logic rst_sync1_r;
  logic rst_sync2_r;
  logic rst_n;

  wdt_pkg::wdt_state_t state_r;
  wdt_pkg::wdt_state_t state_nxt;
  logic [1:0] tt_r;
  logic [1:0] tt_nxt;
  logic action_r;
  logic action_nxt;
  logic [1:0] count_r;
  logic [1:0] count_nxt;
  logic irq_r;
  logic irq_nxt;
  logic [7:0] rd_data_r;
  logic [7:0] rd_data_nxt;

  logic wr_ctrl;
  logic wr_key;
  logic clear_wr;
  logic disable_wr;
  logic hold;
  logic use_low;
  logic tick;
  logic counting;
  logic overflow;
  logic reset_trig;

  // Reset release passes two flops; assertion stays asynchronous
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_sync1_r <= 1'b0;
      rst_sync2_r <= 1'b0;
    end
    else
    begin
      rst_sync1_r <= 1'b1;
      rst_sync2_r <= rst_sync1_r;
    end
  end

  assign rst_n = rst_sync2_r;

  // Mode decode; mode inputs come from logic on this clock
  assign hold = stop_mode_in | idle_mode_in | sleep_mode_in;
  assign use_low = slow_mode_in | divider_stage_select_in;

  // Divider taps feeding the binary counter
  wdt_divider #(
    .HF_BITS(HF_DIV_BITS),
    .LF_BITS(LF_DIV_BITS)
  ) u_divider (
    .clock_in(clock_in),
    .rst_n_in(rst_n),
    .low_freq_clock_in(low_freq_clock_in),
    .hold_in(hold),
    .use_low_in(use_low),
    .time_sel_in(tt_r),
    .tick_out(tick)
  );

  // Register port decode
  assign wr_ctrl = wr_en_in && (addr_in == `WDT_ADDR_CTRL_ONE);
  assign wr_key = wr_en_in && (addr_in == `WDT_ADDR_KEY_CODE);
  assign clear_wr = wr_key && (wr_data_in == `WDT_CODE_CLEAR);
  assign disable_wr = wr_key && (wr_data_in == `WDT_CODE_DISABLE);

  // Counter keeps running, except in the hold modes, until the disable code lands
  assign counting = (state_r != wdt_pkg::WDT_ST_OFF) && !hold;
  // A clear in the tick cycle wins, so software never loses a late kick
  assign overflow = tick && counting && !clear_wr && (count_r == 2'h3);
  assign reset_trig = overflow && action_r;

  // Configuration and enable state
  always_comb
  begin
    state_nxt = state_r;
    tt_nxt = tt_r;
    action_nxt = action_r;
    if (wr_ctrl)
    begin
      tt_nxt = wr_data_in[`WDT_BIT_TT_HI:`WDT_BIT_TT_LO];
      // Only a step from reset to interrupt is possible
      action_nxt = action_r & wr_data_in[`WDT_BIT_ACTION];
      if (wr_data_in[`WDT_BIT_ENABLE])
      begin
        state_nxt = wdt_pkg::WDT_ST_RUN;
      end
      else if (state_r == wdt_pkg::WDT_ST_RUN)
      begin
        state_nxt = wdt_pkg::WDT_ST_ARMED_OFF;
      end
    end
    else if (disable_wr && state_r == wdt_pkg::WDT_ST_ARMED_OFF)
    begin
      state_nxt = wdt_pkg::WDT_ST_OFF;
    end
    // Other key values change nothing here
  end

  always_ff @(posedge clock_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= wdt_pkg::WDT_ST_RUN;
      tt_r <= `WDT_TT_RESET;
      action_r <= `WDT_ACTION_RESET;
    end
    else
    begin
      state_r <= state_nxt;
      tt_r <= tt_nxt;
      action_r <= action_nxt;
    end
  end

  // Two-stage binary counter; overflow on the fourth tap tick
  always_comb
  begin
    count_nxt = count_r;
    if (state_r == wdt_pkg::WDT_ST_OFF)
    begin
      count_nxt = 2'h0;
    end
    else if (clear_wr)
    begin
      count_nxt = 2'h0;
    end
    else if (tick && counting)
    begin
      count_nxt = count_r + 2'h1;
    end
    // Periodic use: interrupt at every overflow, no mask in this path
    irq_nxt = overflow && !action_r;
  end

  always_ff @(posedge clock_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_r <= 2'h0;
      irq_r <= 1'b0;
    end
    else
    begin
      count_r <= count_nxt;
      irq_r <= irq_nxt;
    end
  end

  // Reset request held for the fixed reset time
  wdt_reset_stretch u_reset_stretch (
    .clock_in(clock_in),
    .rst_n_in(rst_n),
    .trig_in(reset_trig),
    .active_out(wdt_reset_request_out)
  );

  // Read path: control and key registers are write-only
  always_comb
  begin
    rd_data_nxt = 8'h00;
    if (rd_en_in)
    begin
      case (addr_in)
        `WDT_ADDR_CTRL_ONE: rd_data_nxt = 8'h00;
        `WDT_ADDR_KEY_CODE: rd_data_nxt = 8'h00;
        `WDT_ADDR_STATUS: rd_data_nxt = {hold,
                                         state_r != wdt_pkg::WDT_ST_OFF,
                                         count_r, tt_r, action_r,
                                         state_r == wdt_pkg::WDT_ST_RUN};
        default: rd_data_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_data_r <= 8'h00;
    end
    else
    begin
      rd_data_r <= rd_data_nxt;
    end
  end

  assign rd_data_out = rd_data_r;
  assign watchdog_interrupt_request_out = irq_r;

endmodule
`default_nettype wire

// [test/wdt_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
`include "wdt_map.svh"

module wdt_monitor (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic stop_mode_in,
  input wire logic idle_mode_in,
  input wire logic sleep_mode_in,
  input wire logic [7:0] rd_data_out,
  input wire logic watchdog_interrupt_request_out,
  input wire logic wdt_reset_request_out
);
  logic [5:0] hi_cnt_r;
  logic [5:0] hi_cnt_nxt;
  logic hold;
  logic irq;
  logic rq;

  // Length of the reset request seen so far
  always_comb
  begin
    hi_cnt_nxt = rq ? hi_cnt_r + 6'h01 : 6'h00;
  end

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      hi_cnt_r <= 6'h00;
    else
      hi_cnt_r <= hi_cnt_nxt;
  end

  // Short names keep the properties readable
  assign hold = stop_mode_in | idle_mode_in | sleep_mode_in;
  assign irq = watchdog_interrupt_request_out;
  assign rq = wdt_reset_request_out;

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);

  // Overflow needs four ticks, so pulses are never closer than four cycles
  a_irq_single_pulse: assert property (irq |=> !irq [*3])
    else $error("interrupt pulse too long or too close");
  a_reset_max_width: assert property (hi_cnt_r <= 6'h18)
    else $error("reset request longer than 24 cycles");
  a_reset_full_width: assert property (
    $fell(rq) |-> hi_cnt_r == 6'h18)
    else $error("reset request width not 24 cycles");
  a_read_idle_zero: assert property (
    rd_data_out != 8'h00 |->
    $past(rd_en_in) && $past(addr_in) == `WDT_ADDR_STATUS)
    else $error("read data outside a status read");
  a_write_only_zero: assert property (
    rd_en_in && addr_in != `WDT_ADDR_STATUS |=> rd_data_out == 8'h00)
    else $error("write-only register gave data");
  a_clear_quiet: assert property (
    wr_en_in && addr_in == `WDT_ADDR_KEY_CODE &&
    wr_data_in == `WDT_CODE_CLEAR |=> !irq [*3])
    else $error("overflow right after clear code");
  a_hold_no_event: assert property (
    $past(hold, 2) && $past(hold) && hold |-> !irq && !$rose(rq))
    else $error("overflow while count is frozen");
  a_start_quiet: assert property (
    $rose(rst_n_in) |-> !(irq || rq) [*2])
    else $error("event right after reset release");

  c_irq: cover property (irq);
  c_reset_req: cover property ($rose(rq));
  c_status_read: cover property ($past(rd_en_in) && rd_data_out != 8'h00);
  c_hold: cover property ($past(hold) && hold);
endmodule

bind wdt_top wdt_monitor i_mon (.clock_in(clock_in), .rst_n_in(rst_n_in),
  .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in),
  .rd_en_in(rd_en_in), .stop_mode_in(stop_mode_in),
  .idle_mode_in(idle_mode_in), .sleep_mode_in(sleep_mode_in),
  .rd_data_out(rd_data_out),
  .watchdog_interrupt_request_out(watchdog_interrupt_request_out),
  .wdt_reset_request_out(wdt_reset_request_out));

`default_nettype wire

// [test/watchdog_timer_test.sv]
`timescale 1ns/10ps
`default_nettype none

module watchdog_timer_test;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [7:0] wr_data_in = 8'h00;
  logic wr_en_in = 1'b0, rd_en_in = 1'b0, low_freq_clock_in = 1'b0;
  logic slow_mode_in = 1'b0, stop_mode_in = 1'b0, idle_mode_in = 1'b0;
  logic sleep_mode_in = 1'b0, divider_stage_select_in = 1'b0;
  logic [7:0] rd_data_out, rd, r0;
  logic irq, rq;
  logic [2:0] lf_div = 3'h0;
  int miscompares = 0, checked = 0, n;
  // Address, data, expected status, status mask
  logic [31:0] rows [8] = '{32'h36FF43CF, 32'h354E43FF, 32'h340D4BCF,
    32'h35554BCF, 32'h35B14BCF, 32'h340448CF, 32'h35B108FF, 32'h340F4DCF};
  // Slow mode, stage select, control value, pulses in 64 cycles
  logic [31:0] mrows [4] = '{32'h00000E10, 32'h00000C04, 32'h00010E02,
    32'h01000E02};

  // Clock and a low clock of eight cycles
  always #2.5 clock_in = ~clock_in;
  always @(posedge clock_in) lf_div <= lf_div + 3'h1;
  always @(posedge clock_in) low_freq_clock_in <= lf_div[2];

  wdt_top #(.HF_DIV_BITS(6), .LF_DIV_BITS(6)) i_dut (.clock_in(clock_in),
    .rst_n_in(rst_n_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
    .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
    .low_freq_clock_in(low_freq_clock_in), .slow_mode_in(slow_mode_in),
    .stop_mode_in(stop_mode_in), .idle_mode_in(idle_mode_in),
    .sleep_mode_in(sleep_mode_in),
    .divider_stage_select_in(divider_stage_select_in),
    .rd_data_out(rd_data_out), .watchdog_interrupt_request_out(irq),
    .wdt_reset_request_out(rq));

  // Bus helpers, comparison and closing
  task check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      miscompares++;
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr_in <= a;
    wr_data_in <= d;
    wr_en_in <= 1'b1;
    @(posedge clock_in);
    wr_en_in <= 1'b0;
  endtask
  task rd_reg(input logic [7:0] a);
    @(posedge clock_in);
    addr_in <= a;
    rd_en_in <= 1'b1;
    @(posedge clock_in);
    rd_en_in <= 1'b0;
    @(negedge clock_in);
    rd = rd_data_out;
  endtask
  // A reset request in interrupt mode spoils the pulse count
  task count_irq(input int cyc);
    n = 0;
    repeat (cyc)
    begin
      @(negedge clock_in);
      if (irq === 1'b1)
        n++;
      if (rq !== 1'b0)
        n += 100;
    end
  endtask
  task do_reset;
    @(posedge clock_in);
    rst_n_in <= 1'b0;
    repeat (8) @(posedge clock_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge clock_in);
  endtask
  task test_done;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Hang guard
  initial
  begin
    #50000;
    miscompares++;
    test_done;
  end

  // Main sequence
  initial
  begin
    do_reset;
    foreach (rows[i])
    begin
      wr(rows[i][31:24], rows[i][23:16]);
      rd_reg(8'h36);
      r0 = rd & rows[i][7:0];
      check(r0, rows[i][15:8]);
    end
    foreach (rows[i])
    begin
      rd_reg(i[0] ? 8'h35 : (i[1] ? 8'h80 : 8'h34));
      check(rd, 8'h00);
    end
    foreach (mrows[i])
    begin
      @(posedge clock_in);
      slow_mode_in <= mrows[i][24];
      divider_stage_select_in <= mrows[i][16];
      wr(8'h34, mrows[i][15:8]);
      repeat (40) @(posedge clock_in);
      count_irq(64);
      check(8'(n), mrows[i][7:0]);
    end
    @(posedge clock_in);
    slow_mode_in <= 1'b0;
    for (int m = 0; m < 3; m++)
    begin
      // Kick just before the freeze so the held count starts low
      wr(8'h35, 8'h4E);
      @(posedge clock_in);
      {sleep_mode_in, idle_mode_in, stop_mode_in} <= 3'h1 << m;
      rd_reg(8'h36);
      r0 = rd;
      count_irq(20);
      check(8'(n), 8'h00);
      rd_reg(8'h36);
      check(rd, r0);
      check(r0 & 8'h80, 8'h80);
      @(posedge clock_in);
      {sleep_mode_in, idle_mode_in, stop_mode_in} <= 3'h0;
      wr(8'h35, 8'h4E);
      repeat (4) @(posedge clock_in);
      count_irq(8);
      check(8'(n), 8'h02);
    end
    // Clears every two cycles keep the count from reaching overflow
    wr(8'h35, 8'h4E);
    fork
      count_irq(20);
      repeat (10) wr(8'h35, 8'h4E);
    join
    check(8'(n), 8'h00);
    // Second reset: back to reset action, counting with no writes
    do_reset;
    n = 0;
    while (rq !== 1'b1 && n < 400)
    begin
      @(negedge clock_in);
      n++;
    end
    check(8'(n < 400), 8'h01);
    n = 0;
    while (rq === 1'b1 && n < 40)
    begin
      @(negedge clock_in);
      n++;
    end
    check(8'(n), 8'h18);
    test_done;
  end
endmodule

`default_nettype wire
